// ==== inc/gapc_pkg.sv ====
// Package: constants, register map and types of the gauge access and pin control block
package gapc_pkg;

  // Register byte offsets (AHB-Lite, one word each)
  localparam logic [7:0] OFS_SEC_MODE   = 8'h00;
  localparam logic [7:0] OFS_KEY_ENTRY  = 8'h04;
  localparam logic [7:0] OFS_CFG_A      = 8'h08;
  localparam logic [7:0] OFS_CFG_B      = 8'h0C;
  localparam logic [7:0] OFS_CONTROL    = 8'h10;
  localparam logic [7:0] OFS_CTRL_STAT  = 8'h14;
  localparam logic [7:0] OFS_VOLTAGE    = 8'h18;
  localparam logic [7:0] OFS_TEMP       = 8'h1C;
  localparam logic [7:0] OFS_CURRENT    = 8'h20;
  localparam logic [7:0] OFS_COULOMB    = 8'h24;
  localparam logic [7:0] OFS_POWER      = 8'h28;
  localparam logic [7:0] OFS_GEN_PARAM  = 8'h2C;
  localparam logic [7:0] OFS_FULL_KEY   = 8'h30;
  localparam logic [7:0] OFS_OPEN_KEY   = 8'h34;
  localparam logic [7:0] OFS_ACC_STAT   = 8'h38;
  localparam logic [7:0] OFS_MFG_BASE   = 8'h80;
  localparam logic [7:0] OFS_MFG_END    = 8'hDF;

  // Manufacturer storage: 3 blocks of 32 bytes, held as 8 words each
  localparam int MFG_BLOCKS      = 3;
  localparam int MFG_BLOCK_BYTES = 32;
  localparam int MFG_TOTAL_BYTES = 96;
  localparam int MFG_WORDS       = MFG_TOTAL_BYTES / 4;
  localparam int MFG_BLK_WORDS   = MFG_BLOCK_BYTES / 4;

  // Field positions
  localparam int CFGA_TEMP_SRC   = 0;
  localparam int CFGA_SD_EN      = 1;
  localparam int CFGA_SD_POL     = 2;
  localparam int CFGB_CHARGE_STOP_ENABLE     = 0;
  localparam int CFGB_CHARGE_STOP_POLARITY    = 1;
  localparam int CSW_PIN_ACTIVE  = 0;
  localparam int CSW_ARMED       = 1;
  localparam int CSW_FULL_CHG    = 2;
  localparam int CSW_TEMP_FAULT  = 3;

  // Reset values
  localparam logic [2:0] CFGA_RESET = 3'b110;
  localparam logic [1:0] CFGB_RESET = 2'b11;
  // Arbitrary default keys
  localparam logic [31:0] FULL_KEY_RESET = 32'h0000_0000;
  localparam logic [31:0] OPEN_KEY_RESET = 32'h0000_0001;

  // Subcommands
  localparam logic [15:0] CMD_ARM_SHUTDOWN    = 16'h0013;
  localparam logic [15:0] CMD_DISARM_SHUTDOWN = 16'h0014;
  localparam logic [15:0] CMD_LOCK            = 16'h0020;

  // Timing
  localparam int  CLK_HZ          = 40_000_000;
  localparam int  REFRESH_MS      = 1000;
  localparam int  REFRESH_CYC     = CLK_HZ / 1000 * REFRESH_MS;
  localparam int  SLOT_CYC        = REFRESH_CYC / 4;
  localparam int  SAMPLE_LINK_DIV = 1;
  localparam int  CC_FRAC_BITS    = 8;

  typedef enum logic [1:0] {
    GAPC_KEY_WRITE,
    GAPC_OPEN,
    GAPC_LOCKED
  } gapc_sec_t;

  typedef enum logic [1:0] {
    GAPC_NORMAL,
    GAPC_SLEEP,
    GAPC_FULL_SLEEP,
    GAPC_HIBERNATE
  } gapc_pwr_t;

  typedef enum logic [1:0] {
    GAPC_MEAS_VOLT,
    GAPC_MEAS_TEMP,
    GAPC_MEAS_CURR
  } gapc_meas_t;

  // Access rights of one region
  typedef struct packed {
    logic rd;
    logic wr;
  } gapc_rights_t;

  // Measurement results
  typedef struct packed {
    logic [15:0] volt_mv;
    logic [15:0] temp_dk;
    logic [15:0] curr_ma;
  } gapc_meas_res_t;

endpackage : gapc_pkg

// ==== hdl/gapc_sync.sv ====
// Two-flip-flop synchroniser for pin inputs
module gapc_sync #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         hclk,
  input  wire logic         hresetn,
  // Data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : gapc_sync

// ==== hdl/gapc_measure.sv ====
// Measurement sequencer and coulomb counter
module gapc_measure
  import gapc_pkg::*;
(
  // Clock and reset
  input  wire logic           hclk,
  input  wire logic           hresetn,
  // Control
  input  wire logic           run,
  input  wire logic           temp_src,
  // Synchronised converter samples
  input  wire logic [15:0]    adc_volt,
  input  wire logic [15:0]    adc_temp_int,
  input  wire logic [15:0]    adc_temp_ext,
  input  wire logic [15:0]    adc_curr,
  // Results
  output gapc_meas_res_t      res,
  output logic                charging,
  output logic [31:0]         coulomb,
  output logic                refresh
);
  gapc_meas_t  state_q;
  logic [31:0] slot_cnt_q;
  logic [CC_FRAC_BITS-1:0] frac_q;
  logic        slot_end;

  assign slot_end = (slot_cnt_q == 32'(SLOT_CYC - 1));

  // Slot timer: four slots per second, all results refreshed within 1 s
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      slot_cnt_q <= '0;
    end else if (!run || slot_end) begin
      slot_cnt_q <= '0;
    end else begin
      slot_cnt_q <= slot_cnt_q + 32'd1;
    end
  end

  // Sequence repeats while in normal mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= GAPC_MEAS_VOLT;
    end else if (run && slot_end) begin
      case (state_q)
        GAPC_MEAS_VOLT: state_q <= GAPC_MEAS_TEMP;
        GAPC_MEAS_TEMP: state_q <= GAPC_MEAS_CURR;
        GAPC_MEAS_CURR: state_q <= GAPC_MEAS_VOLT;
        default:        state_q <= GAPC_MEAS_VOLT;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      res      <= '0;
      charging <= 1'b0;
      refresh  <= 1'b0;
    end else begin
      refresh <= run && slot_end;
      if (run && slot_end) begin
        case (state_q)
          GAPC_MEAS_VOLT: res.volt_mv <= adc_volt;
          GAPC_MEAS_TEMP: res.temp_dk <= temp_src ? adc_temp_ext : adc_temp_int;
          GAPC_MEAS_CURR: begin
            res.curr_ma <= adc_curr;
            // Positive sense voltage means charging
            charging    <= !adc_curr[15] && (adc_curr != 16'h0000);
          end
          default: ;
        endcase
      end
    end
  end

  // Integrates each current sample; fraction keeps sub-step residue
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      coulomb <= '0;
      frac_q  <= '0;
    end else if (run && slot_end && state_q == GAPC_MEAS_CURR) begin
      {coulomb, frac_q} <= 40'({coulomb, frac_q} + {{24{adc_curr[15]}}, adc_curr});
    end
  end
endmodule : gapc_measure

// ==== hdl/gapc_top.sv ====
// Gauge security modes, measurement access and shutdown/temperature/charge-stop pins
// Summary of operation
// - Key-write mode grants full access
// - Open mode: keys readable, not writable
// - Locked: block A read, B/C read-write
// - Keys writable only in key-write mode
// - 96 bytes, three 32-byte manufacturer blocks
// - Normal mode measures continuously, results readable
// - Results refreshed at least each second
// - Temperature source selected by config bit
// - Positive sense is charging, 1mA units
// - Current integrated in coulomb counter
// - Four power states, saving needs voltage
// - Shutdown pin shows hibernate, quiet at reset
// - Shutdown enable bit activates the pin
// - Arm command enables shutdown, sets flag
// - Disarm command clears flag, disables shutdown unless enable bit set
// - Pin-active flag follows enable-driven activity
// - Armed flag set only by arm command
// - Polarity bit picks pin active level
// - Temperature-good low when safe, high on fault
// - Full charge on threshold or stop input
// - Stop input used only when enabled
// - Stop polarity bit picks input active level
module gapc_top
  import gapc_pkg::*;
(
  // AHB-Lite slave
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Converter samples and analog status (asynchronous)
  input  wire logic [15:0] adc_volt,
  input  wire logic [15:0] adc_temp_int,
  input  wire logic [15:0] adc_temp_ext,
  input  wire logic [15:0] adc_curr,
  input  wire logic        above_por,
  input  wire logic        temp_fault,
  input  wire logic        charge_threshold_met,
  // Pins
  input  wire logic        charge_stop_input,
  output logic             shutdown_indicator_pin,
  output logic             temp_good_n,
  // Status
  output logic             full_charge
);
  gapc_sec_t      sec_q;
  gapc_pwr_t      pwr_q;
  logic [2:0]     cfga_q;
  logic [1:0]     cfgb_q;
  logic [31:0]    full_key_q;
  logic [31:0]    open_key_q;
  logic [31:0]    gen_param_q;
  logic [31:0]    mfg_q [MFG_WORDS];
  logic           armed_q;
  logic           deny_q;
  logic           por_done_q;
  logic [1:0]     pwr_req_q;
  logic [7:0]     addr_q;
  logic           wr_q;
  logic           rd_q;
  logic           wr_en;
  logic [31:0]    rdata;
  logic           sd_active;
  gapc_rights_t   gen_r;
  gapc_rights_t   key_r;
  gapc_rights_t   mfg_r [MFG_BLOCKS];
  logic [15:0]    volt_s, tint_s, text_s, curr_s;
  logic           por_s, tfault_s, thr_s, stop_s;
  gapc_meas_res_t res;
  logic           charging;
  logic [31:0]    coulomb;
  logic           stop_asserted;
  logic           in_mfg;
  logic [4:0]     mfg_idx;
  logic [1:0]     mfg_blk;

  // Pin and analog inputs cross in through two flops
  gapc_sync #(.W(68)) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .d       ({adc_volt, adc_temp_int, adc_temp_ext, adc_curr,
                above_por, temp_fault, charge_threshold_met, charge_stop_input}),
    .q       ({volt_s, tint_s, text_s, curr_s, por_s, tfault_s, thr_s, stop_s})
  );

  gapc_measure u_meas (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .run          (pwr_q == GAPC_NORMAL),
    .temp_src     (cfga_q[CFGA_TEMP_SRC]),
    .adc_volt     (volt_s),
    .adc_temp_int (tint_s),
    .adc_temp_ext (text_s),
    .adc_curr     (curr_s),
    .res          (res),
    .charging     (charging),
    .coulomb      (coulomb),
    .refresh      ()
  );

  // Access rights by security mode
  always_comb begin
    gen_r = '{rd: 1'b0, wr: 1'b0};
    key_r = '{rd: 1'b0, wr: 1'b0};
    for (int b = 0; b < MFG_BLOCKS; b++) begin
      mfg_r[b] = '{rd: 1'b1, wr: 1'b1};
    end
    case (sec_q)
      GAPC_KEY_WRITE: begin
        gen_r = '{rd: 1'b1, wr: 1'b1};
        key_r = '{rd: 1'b1, wr: 1'b1};
      end
      GAPC_OPEN: begin
        gen_r = '{rd: 1'b1, wr: 1'b1};
        key_r = '{rd: 1'b1, wr: 1'b0};
      end
      GAPC_LOCKED: begin
        mfg_r[0] = '{rd: 1'b1, wr: 1'b0};
      end
      default: ;
    endcase
  end

  // AHB-Lite address phase capture; writes have no wait state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= '0;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
    end else if (hready) begin
      addr_q <= haddr;
      wr_q   <= hsel && htrans[1] && hwrite;
      rd_q   <= hsel && htrans[1] && !hwrite;
    end
  end

  assign wr_en   = wr_q;
  assign in_mfg  = (addr_q >= OFS_MFG_BASE) && (addr_q <= OFS_MFG_END);
  assign mfg_idx = 5'((addr_q - OFS_MFG_BASE) >> 2);
  assign mfg_blk = 2'(mfg_idx / 5'(MFG_BLK_WORDS));

  // Manufacturer storage
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < MFG_WORDS; i++) begin
        mfg_q[i] <= '0;
      end
    end else if (wr_en && in_mfg && mfg_r[mfg_blk].wr) begin
      mfg_q[mfg_idx] <= hwdata;
    end
  end

  // Configuration, general parameter and keys
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfga_q      <= CFGA_RESET;
      cfgb_q      <= CFGB_RESET;
      gen_param_q <= '0;
      full_key_q  <= FULL_KEY_RESET;
      open_key_q  <= OPEN_KEY_RESET;
    end else if (wr_en) begin
      case (addr_q)
        OFS_CFG_A:     if (gen_r.wr) cfga_q <= hwdata[2:0];
        OFS_CFG_B:     if (gen_r.wr) cfgb_q <= hwdata[1:0];
        OFS_GEN_PARAM: if (gen_r.wr) gen_param_q <= hwdata;
        OFS_FULL_KEY:  if (key_r.wr) full_key_q <= hwdata;
        OFS_OPEN_KEY:  if (key_r.wr) open_key_q <= hwdata;
        default: ;
      endcase
    end
  end

  // Security mode: keys move up, lock command moves to locked
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sec_q <= GAPC_LOCKED;
    end else if (wr_en && addr_q == OFS_KEY_ENTRY) begin
      if (hwdata == full_key_q && sec_q == GAPC_OPEN) begin
        sec_q <= GAPC_KEY_WRITE;
      end else if (hwdata == open_key_q && sec_q == GAPC_LOCKED) begin
        sec_q <= GAPC_OPEN;
      end
    end else if (wr_en && addr_q == OFS_CONTROL && hwdata[15:0] == CMD_LOCK) begin
      sec_q <= GAPC_LOCKED;
    end
  end

  // Arm and disarm subcommands; only arm sets the flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      armed_q <= 1'b0;
    end else if (wr_en && addr_q == OFS_CONTROL) begin
      if (hwdata[15:0] == CMD_ARM_SHUTDOWN) begin
        armed_q <= 1'b1;
      end else if (hwdata[15:0] == CMD_DISARM_SHUTDOWN) begin
        armed_q <= 1'b0;
      end
    end
  end

  // Sticky denial status, set wins over clear
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      deny_q <= 1'b0;
    end else if (wr_en && ((in_mfg && !mfg_r[mfg_blk].wr) ||
                 ((addr_q == OFS_CFG_A || addr_q == OFS_CFG_B ||
                   addr_q == OFS_GEN_PARAM) && !gen_r.wr) ||
                 ((addr_q == OFS_FULL_KEY || addr_q == OFS_OPEN_KEY) && !key_r.wr))) begin
      deny_q <= 1'b1;
    end else if (wr_en && addr_q == OFS_ACC_STAT && hwdata[0]) begin
      deny_q <= 1'b0;
    end
  end

  // Power states; saving states only above the reset threshold
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_req_q <= 2'd0;
    end else if (wr_en && addr_q == OFS_POWER) begin
      pwr_req_q <= hwdata[1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pwr_q <= GAPC_NORMAL;
    end else if (!por_s) begin
      pwr_q <= GAPC_NORMAL;
    end else begin
      case (pwr_req_q)
        2'd0:    pwr_q <= GAPC_NORMAL;
        2'd1:    pwr_q <= GAPC_SLEEP;
        2'd2:    pwr_q <= GAPC_FULL_SLEEP;
        2'd3:    pwr_q <= GAPC_HIBERNATE;
        default: pwr_q <= GAPC_NORMAL;
      endcase
    end
  end

  // Power-on-reset window ends while supply is seen above threshold, reopens when it falls
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_done_q <= 1'b0;
    end else begin
      por_done_q <= por_s;
    end
  end

  // Pin active when enabled by config or armed, and in hibernate
  assign sd_active = por_done_q && (cfga_q[CFGA_SD_EN] || armed_q)
                     && (pwr_q == GAPC_HIBERNATE);

  // Output pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shutdown_indicator_pin <= 1'b0;
      temp_good_n            <= 1'b0;
    end else begin
      // Polarity applies while enabled or armed; disarmed and disabled pulls low
      if (!(cfga_q[CFGA_SD_EN] || armed_q)) begin
        shutdown_indicator_pin <= 1'b0;
      end else begin
        shutdown_indicator_pin <= sd_active ~^ cfga_q[CFGA_SD_POL];
      end
      temp_good_n <= por_done_q && tfault_s;
    end
  end

  assign stop_asserted = cfgb_q[CFGB_CHARGE_STOP_ENABLE]
                         && (stop_s ~^ cfgb_q[CFGB_CHARGE_STOP_POLARITY]);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      full_charge <= 1'b0;
    end else begin
      full_charge <= thr_s || stop_asserted;
    end
  end

  // Read multiplexer
  always_comb begin
    rdata = 32'h0000_0000;
    if (in_mfg) begin
      if (mfg_r[mfg_blk].rd) rdata = mfg_q[mfg_idx];
    end else begin
      case (addr_q)
        OFS_SEC_MODE:  rdata = {30'h0, sec_q};
        OFS_CFG_A:     if (gen_r.rd) rdata = {29'h0, cfga_q};
        OFS_CFG_B:     if (gen_r.rd) rdata = {30'h0, cfgb_q};
        OFS_CTRL_STAT: rdata = {28'h0, por_done_q && tfault_s, full_charge,
                                armed_q, sd_active && cfga_q[CFGA_SD_EN]};
        OFS_VOLTAGE:   rdata = {16'h0, res.volt_mv};
        OFS_TEMP:      rdata = {16'h0, res.temp_dk};
        OFS_CURRENT:   rdata = {15'h0, charging, res.curr_ma};
        OFS_COULOMB:   rdata = coulomb;
        OFS_POWER:     rdata = {30'h0, pwr_q};
        OFS_GEN_PARAM: if (gen_r.rd) rdata = gen_param_q;
        OFS_FULL_KEY:  if (key_r.rd) rdata = full_key_q;
        OFS_OPEN_KEY:  if (key_r.rd) rdata = open_key_q;
        OFS_ACC_STAT:  rdata = {31'h0, deny_q};
        default:       rdata = 32'h0000_0000;
      endcase
    end
  end

  // Reads take one wait state so that read data leaves a flop
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= !(hready && hsel && htrans[1] && !hwrite);
      hresp     <= 1'b0;
    end
  end

  // Read data latched in the wait state, held until the next read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_q && !hreadyout) begin
      hrdata <= rdata;
    end
  end

endmodule : gapc_top

// ==== tb/gapc_top_props.sv ====
// Checker: port-level properties of the gauge access and pin control block
module gapc_top_props
  import gapc_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Bus
  input wire logic        hsel,
  input wire logic [7:0]  haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hresp,
  // Analog status and pins
  input wire logic        temp_fault,
  input wire logic        charge_threshold_met,
  input wire logic        charge_stop_input,
  input wire logic        shutdown_indicator_pin,
  input wire logic        temp_good_n,
  input wire logic        full_charge
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       cfgw_q;
  logic [1:0] cfgb_q;
  wire        take = hsel && hready && htrans[1];

  // Mirrors charge-stop config; only valid while writes to it carry rights
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfgw_q <= 1'b0;
      cfgb_q <= CFGB_RESET;
    end else begin
      cfgw_q <= take && hwrite && (haddr == OFS_CFG_B);
      if (cfgw_q) begin
        cfgb_q <= hwdata[1:0];
      end
    end
  end

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  AST_RESP_OKAY: assert property (hresp == 1'b0)
    else $error("error response seen");
  AST_HOLE_ZERO: assert property (take && !hwrite && haddr >= 8'hE0 |-> ##2 hrdata == 32'h0)
    else $error("unmapped read not zero");
  AST_TGD_FAULT: assert property (temp_fault [*4] |-> temp_good_n)
    else $error("temperature fault not shown");
  AST_TGD_SAFE: assert property ((!temp_fault) [*4] |-> !temp_good_n)
    else $error("temperature good not low");
  AST_FULL_THRESH: assert property (charge_threshold_met [*4] |-> full_charge)
    else $error("threshold did not flag full");
  AST_STOP_OFF: assert property ((!cfgb_q[0] && !charge_threshold_met) [*4] |-> !full_charge)
    else $error("disabled stop input acted");
  AST_STOP_ON: assert property ((cfgb_q[0] && charge_stop_input == cfgb_q[1]) [*4] |-> full_charge)
    else $error("active stop input ignored");
  AST_SD_RST: assert property ($rose(hresetn) |-> !shutdown_indicator_pin)
    else $error("shutdown pin active after reset");

  cover property (take && !hwrite && haddr >= 8'hE0);
  cover property (full_charge ##1 !full_charge);
  cover property ($rose(temp_good_n));
  cover property ($rose(shutdown_indicator_pin));
endmodule : gapc_top_props

bind gapc_top gapc_top_props u_props (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hresp(hresp), .temp_fault(temp_fault),
  .charge_threshold_met(charge_threshold_met), .charge_stop_input(charge_stop_input),
  .shutdown_indicator_pin(shutdown_indicator_pin), .temp_good_n(temp_good_n),
  .full_charge(full_charge));

// ==== tb/gapc_charger_model.sv ====
// Partner: charger and analog front end seen by the gauge block
module gapc_charger_model (
  // Clock
  input wire logic         hclk,
  // Requests from the bench
  input wire logic         stop_act,
  input wire logic         stop_pol,
  input wire logic         fault_req,
  input wire logic         thresh_req,
  input wire logic         por_ok,
  // Toward the gauge
  output logic      [15:0] adc_volt,
  output logic      [15:0] adc_temp_int,
  output logic      [15:0] adc_temp_ext,
  output logic      [15:0] adc_curr,
  output logic             above_por,
  output logic             temp_fault,
  output logic             charge_threshold_met,
  output logic             charge_stop_input
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    adc_volt = 16'h0E10;
    adc_temp_int = 16'h0BB8;
    adc_temp_ext = 16'h0BC2;
    adc_curr = 16'hFF38;
  end
  // Levels move only after a rising edge, as a real charger would be sampled
  always @(posedge hclk) begin
    above_por <= por_ok;
    temp_fault <= fault_req;
    charge_threshold_met <= thresh_req;
    charge_stop_input <= stop_act ? stop_pol : !stop_pol;
  end
endmodule : gapc_charger_model

// ==== tb/tb_top.sv ====
// Testbench: bus checks of security modes, shutdown pin, temperature and charge stop
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import gapc_pkg::*;
  logic        hclk = 1'b0;
  logic        hresetn = 1'b0;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [2:0]  hsize = 3'b010;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hreadyout, hresp, sd_pin, tgd_n, full;
  logic        stop_act = 1'b0, stop_pol = 1'b1, fault_req = 1'b0, thr = 1'b0, por_ok = 1'b1;
  logic [15:0] av, ati, ate, ac;
  logic        ap, tf, ctm, csi;
  int          fails = 0;
  int          check_count = 0;
  logic [1:0]  cfgb_tab [6] = '{2'b10, 2'b01, 2'b01, 2'b11, 2'b11, 2'b11};
  logic [5:0]  act_tab = 6'b001011;
  logic [5:0]  thr_tab = 6'b100000;
  logic [5:0]  exp_tab = 6'b101010;

  always #12.5 hclk = ~hclk;

  gapc_charger_model partner (.hclk(hclk), .stop_act(stop_act), .stop_pol(stop_pol),
    .fault_req(fault_req), .thresh_req(thr), .por_ok(por_ok), .adc_volt(av),
    .adc_temp_int(ati), .adc_temp_ext(ate), .adc_curr(ac), .above_por(ap),
    .temp_fault(tf), .charge_threshold_met(ctm), .charge_stop_input(csi));

  gapc_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .adc_volt(av), .adc_temp_int(ati),
    .adc_temp_ext(ate), .adc_curr(ac), .above_por(ap), .temp_fault(tf),
    .charge_threshold_met(ctm), .charge_stop_input(csi), .shutdown_indicator_pin(sd_pin),
    .temp_good_n(tgd_n), .full_charge(full));

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Bounded wait for the slave's ready at a rising edge
  task automatic wait_rdy();
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 100);
    if (hreadyout !== 1'b1) begin
      fails++;
      print_verdict();
    end
  endtask : wait_rdy

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    wait_rdy();
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(v, exp);
  endtask : rdc

  // Pin paths take four edges: partner, two sync stages and the output register
  task automatic settle();
    repeat (5) @(posedge hclk);
  endtask : settle

  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdc(OFS_SEC_MODE, 32'h2);
    rdc(OFS_CFG_A, 32'h0);
    rdc(OFS_CFG_B, 32'h0);
    rdc(OFS_CTRL_STAT, 32'h0);
    rdc(OFS_GEN_PARAM, 32'h0);
    wr(OFS_GEN_PARAM, 32'h0000_1234);
    rdc(OFS_ACC_STAT, 32'h1);
    wr(OFS_ACC_STAT, 32'h1);
    rdc(OFS_ACC_STAT, 32'h0);
    wr(8'h80, 32'h0000_AAAA);
    rdc(OFS_ACC_STAT, 32'h1);
    wr(OFS_ACC_STAT, 32'h1);
    wr(8'hA0, 32'hB0B0_0001);
    rdc(8'hA0, 32'hB0B0_0001);
    wr(8'hDC, 32'hC0C0_0008);
    rdc(8'hDC, 32'hC0C0_0008);
    rdc(OFS_OPEN_KEY, 32'h0);
    rdc(8'hE0, 32'h0);
    wr(OFS_KEY_ENTRY, OPEN_KEY_RESET);
    rdc(OFS_SEC_MODE, 32'h1);
    wr(OFS_FULL_KEY, 32'h0000_0077);
    rdc(OFS_FULL_KEY, FULL_KEY_RESET);
    rdc(OFS_ACC_STAT, 32'h1);
    wr(8'h9C, 32'hA1A1_0007);
    rdc(8'h9C, 32'hA1A1_0007);
    wr(OFS_GEN_PARAM, 32'h0000_0055);
    rdc(OFS_GEN_PARAM, 32'h0000_0055);
    wr(OFS_KEY_ENTRY, FULL_KEY_RESET);
    rdc(OFS_SEC_MODE, 32'h0);
    rdc(OFS_CFG_A, 32'h6);
    rdc(OFS_CFG_B, 32'h3);
    wr(OFS_FULL_KEY, 32'h0000_0077);
    rdc(OFS_FULL_KEY, 32'h0000_0077);
    wr(OFS_OPEN_KEY, 32'h0000_0033);
    rdc(OFS_OPEN_KEY, 32'h0000_0033);
    for (int i = 0; i < 6; i++) begin
      wr(OFS_CFG_B, {30'h0, cfgb_tab[i]});
      stop_pol <= cfgb_tab[i][1];
      stop_act <= act_tab[i];
      thr <= thr_tab[i];
      settle();
      check({31'h0, full}, {31'h0, exp_tab[i]});
      rdc(OFS_CTRL_STAT, {29'h0, exp_tab[i], 2'b00});
    end
    thr <= 1'b0;
    settle();
    wr(OFS_CONTROL, {16'h0, CMD_ARM_SHUTDOWN});
    rdc(OFS_CTRL_STAT, 32'h2);
    wr(OFS_CONTROL, {16'h0, CMD_DISARM_SHUTDOWN});
    wr(OFS_CFG_A, 32'h4);
    settle();
    check({31'h0, sd_pin}, 32'h0);
    rdc(OFS_CTRL_STAT, 32'h0);
    fault_req <= 1'b1;
    settle();
    check({31'h0, tgd_n}, 32'h1);
    fault_req <= 1'b0;
    settle();
    check({31'h0, tgd_n}, 32'h0);
    wr(OFS_CFG_A, 32'h6);
    wr(OFS_POWER, 32'h3);
    settle();
    check({31'h0, sd_pin}, 32'h1);
    rdc(OFS_CTRL_STAT, 32'h1);
    wr(OFS_CFG_A, 32'h2);
    settle();
    check({31'h0, sd_pin}, 32'h0);
    wr(OFS_CFG_A, 32'h6);
    wr(OFS_POWER, 32'h0);
    por_ok <= 1'b0;
    settle();
    wr(OFS_POWER, 32'h3);
    settle();
    check({31'h0, sd_pin}, 32'h0);
    por_ok <= 1'b1;
    wr(OFS_CONTROL, {16'h0, CMD_LOCK});
    rdc(OFS_SEC_MODE, 32'h2);
    print_verdict();
  end
endmodule : tb_top
